// ==== hw/scpd_core.sv ====
`timescale 1ns/100ps
module scpd_core
  import scpd_pkg::*;
#(
  parameter int SEG_COUNT = 15,
  parameter int BLINK_CNT = scpd_pkg::BLINK_CYC
) (
  input  wire logic                  clk_i,
  input  wire logic                  resetn_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  master_v11_i,
  output logic      [SEG_MAX-1:0]    seg_on_o,
  output logic      [4*SEG_MAX-1:0]  seg_set_o,
  output logic                       tone_on_o,
  output logic      [16*TONE_FIELDS-1:0] tone_o,
  output logic                       led_o,
  output logic                       ps_backup_o
);
  import scpd_pkg::*;

  localparam int MAW = 8;

  scpd_mem_if #(.AW(MAW), .DW(16)) mif ();

  scpd_tone_mem #(.AW(MAW), .DW(16)) u_mem (
    .clk_i (clk_i),
    .port  (mif.mem)
  );

  logic [4:0]        ctrl;
  logic [23:0]       pdata;
  logic [7:0]        tptr;
  logic [6:0]        name_len;
  logic              clamped;
  scpd_seq_e         seq;
  logic [MAW-1:0]    cnt;
  logic              idle_q;
  logic              refresh;
  logic [8:0]        sel_key_q;
  scpd_tone_t        tone;
  scpd_tone_t        stage;
  logic              blink;
  logic [31:0]       blink_cnt;

  // Bus decode
  wire        req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        hit_ctrl = wb_adr_i == ADR_CTRL;
  wire        hit_pd   = wb_adr_i == ADR_PDATA;
  wire        hit_st   = wb_adr_i == ADR_STATUS;
  wire        hit_tp   = wb_adr_i == ADR_TPTR;
  wire        hit_td   = wb_adr_i == ADR_TDATA;
  wire        hit_nm   = wb_adr_i == ADR_NAME;
  // Tone data waits while the sequencer owns the memory port
  wire        td_ready = (seq == SEQ_IDLE) & idle_q;
  wire        go       = req & (~hit_td | td_ready);
  wire        wr       = go & wb_we_i;
  wire [31:0] wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                          {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] wval     = wb_dat_i & wmask;

  // Revision negotiation and derived availability
  wire rev_v11 = ctrl[CTRL_V11EN_BIT] & master_v11_i;
  wire ps_avail = rev_v11;
  wire factory = wr & hit_ctrl & wmask[CTRL_FACTORY_BIT]
               & wb_dat_i[CTRL_FACTORY_BIT];
  wire [6:0] name_max = rev_v11 ? NAME_MAX_V11 : NAME_MAX_V10;
  wire [6:0] name_req = wval[6:0];
  wire       name_big = wval[7] | (name_req > name_max);

  // Process data decode
  scpd_mode_e mode;
  assign mode = scpd_mode_e'(ctrl[CTRL_MODE_LSB +: 2]);
  wire        in_indiv = mode == MODE_INDIV;
  wire        in_fill  = mode == MODE_FILL;
  wire [7:0]  fill    = pdata[7:0];
  wire        fill_ok = fill <= FILL_MAX;
  wire [7:0]  siren   = pdata[PD_SIREN_LSB +: 8];
  wire        siren_ok = (siren >= SIREN_MIN) & (siren <= SIREN_MAX);
  wire        custom  = ctrl[CTRL_CUSTOM_BIT];
  wire [11:0] fill_prod = 12'(fill) * 12'(SEG_COUNT);
  wire [11:0] lit_cnt   = fill_prod / 12'(FILL_MAX);
  wire [3:0]  slot      = 4'(siren - SIREN_MIN);
  wire [8:0]  sel_key   = {custom, siren};

  // Segment computation per segment
  logic [SEG_MAX-1:0]   next_seg_on;
  logic [4*SEG_MAX-1:0] next_seg_set;
  genvar g;
  generate
    for (g = 0; g < SEG_MAX; g++) begin : g_seg
      wire present = g < SEG_COUNT;
      wire in_bar  = 12'(g) < lit_cnt;
      // Bit 15 of the process word never feeds a segment
      wire indiv_on = pdata[g];
      assign next_seg_on[g] = present &
        (in_indiv ? indiv_on :
         in_fill  ? (fill_ok & in_bar) : 1'b0);
      // Colour option collapses to segment 1 only in fill mode
      assign next_seg_set[4*g +: 4] =
        (in_fill && ctrl[CTRL_FILLCOL_BIT]) ? 4'h1
                                            : 4'(g + 1);
    end
  endgenerate

  // Memory port ownership
  assign mif.addr  = (seq == SEQ_IDLE) ? tptr
                   : (seq == SEQ_FETCH) ? {slot, cnt[3:0]} : cnt;
  assign mif.we    = (seq == SEQ_CLEAR) | (wr & hit_td);
  assign mif.wdata = (seq == SEQ_CLEAR) ? 16'h0000 : wb_dat_i[15:0];

  // Readback selection
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[4:0] = ctrl;
    end else if (hit_pd) begin
      rd_mux[23:0] = pdata;
    end else if (hit_st) begin
      rd_mux[SEG_MAX-1:0] = seg_on_o;
      rd_mux[ST_REV_BIT]  = rev_v11;
      rd_mux[ST_FILLBAD]  = ~fill_ok;
      rd_mux[ST_SIRENBAD] = ~siren_ok;
      rd_mux[ST_BUSY]     = seq != SEQ_IDLE;
      rd_mux[ST_CLAMPED]  = clamped;
      rd_mux[ST_PSAVAIL]  = ps_avail;
    end else if (hit_tp) begin
      rd_mux[7:0] = tptr;
    end else if (hit_td) begin
      rd_mux[15:0] = mif.rdata;
    end else if (hit_nm) begin
      rd_mux[6:0] = name_len;
    end
  end

  // Bus answer; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= go;
      wb_dat_o <= go ? rd_mux : 32'h0000_0000;
    end
  end

  // Software registers; factory command restores defaults
  always_ff @(posedge clk_i) begin
    if (!resetn_i || factory) begin
      ctrl     <= CTRL_RESET;
      pdata    <= 24'h00_0000;
      tptr     <= 8'h00;
      name_len <= 7'h00;
      clamped  <= 1'b0;
    end else if (wr) begin
      if (hit_ctrl) begin
        ctrl <= (ctrl & ~wmask[4:0]) | wval[4:0];
      end
      if (hit_pd) begin
        pdata <= (pdata & ~wmask[23:0]) | wval[23:0];
      end
      if (hit_tp && wb_sel_i[0]) begin
        tptr <= wb_dat_i[7:0];
      end
      if (hit_nm && wb_sel_i[0]) begin
        name_len <= name_big ? name_max : name_req;
        clamped  <= name_big;
      end
    end
  end

  // Backup request is dropped under the older revision
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ps_backup_o <= 1'b0;
    end else begin
      ps_backup_o <= wr & hit_ctrl & wmask[CTRL_PSREQ_BIT]
                   & wb_dat_i[CTRL_PSREQ_BIT] & ps_avail;
    end
  end

  // Selection tracker; idle_q delays tone data access by a cycle
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      idle_q    <= 1'b0;
      sel_key_q <= 9'h000;
    end else begin
      idle_q    <= seq == SEQ_IDLE;
      sel_key_q <= sel_key;
    end
  end

  // Sequencer events
  wire sel_moved = sel_key != sel_key_q;
  wire td_write  = wr & hit_td;
  wire take_ref  = (seq == SEQ_IDLE) & refresh;
  // Count runs one past the last field to cover the read latency
  wire fetch_end = (seq == SEQ_FETCH) & (cnt == MAW'(TONE_FIELDS));
  wire clr_done  = (seq == SEQ_CLEAR) & (&cnt);
  // A custom record with an unknown type stays silent
  wire type_ok   = stage[0] <= 16'(TONE_SWEEP);
  wire load_pre  = take_ref & siren_ok & ~custom;
  wire start_fet = take_ref & siren_ok & custom;
  // Silence on a bad selection, and while a custom record loads
  wire mute      = take_ref & ~load_pre;

  // Edits of tone data or selection re-evaluate the siren;
  // a new event in the consuming cycle wins so none is lost
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      refresh <= 1'b1;
    end else if (sel_moved || td_write || clr_done) begin
      refresh <= 1'b1;
    end else if (take_ref) begin
      refresh <= 1'b0;
    end
  end

  // Tone sequencer: custom fetch and memory wipe
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      seq <= SEQ_IDLE;
      cnt <= '0;
    end else if (factory) begin
      seq <= SEQ_CLEAR;
      cnt <= '0;
    end else begin
      unique case (seq)
        SEQ_IDLE: begin
          cnt <= '0;
          if (start_fet) begin
            seq <= SEQ_FETCH;
          end
        end
        SEQ_FETCH: begin
          if (fetch_end) begin
            seq <= SEQ_IDLE;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        SEQ_CLEAR: begin
          if (clr_done) begin
            seq <= SEQ_IDLE;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        default: seq <= SEQ_IDLE;
      endcase
    end
  end

  // Fetched fields gather here so the siren never sees half a record
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      stage <= '0;
    end else if (seq == SEQ_FETCH && cnt != '0) begin
      // Read data lags the address by one cycle
      stage[cnt[3:0] - 4'h1] <= mif.rdata;
    end
  end

  // Siren output; a record goes out whole, the factory command mutes
  always_ff @(posedge clk_i) begin
    if (!resetn_i || factory || mute) begin
      tone      <= '0;
      tone_on_o <= 1'b0;
    end else if (load_pre) begin
      tone      <= scpd_preset(siren);
      tone_on_o <= 1'b1;
    end else if (fetch_end && type_ok) begin
      // Last field arrives with the closing cycle
      tone      <= {mif.rdata, stage[TONE_FIELDS-2:0]};
      tone_on_o <= 1'b1;
    end
  end

  assign tone_o = tone;

  // Divider: one enable pulse per half period of the LED blink
  wire blink_tick = blink_cnt >= 32'(BLINK_CNT - 1);
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      blink_cnt <= 32'h0000_0000;
    end else if (blink_tick) begin
      blink_cnt <= 32'h0000_0000;
    end else begin
      blink_cnt <= blink_cnt + 32'h0000_0001;
    end
  end

  // LED phase moves only on the divider enable
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      blink <= 1'b0;
    end else if (blink_tick) begin
      blink <= ~blink;
    end
  end

  // Registered display outputs
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      seg_on_o  <= '0;
      seg_set_o <= '0;
      led_o     <= 1'b0;
    end else begin
      seg_on_o  <= next_seg_on;
      seg_set_o <= next_seg_set;
      led_o     <= rev_v11 ? blink : 1'b1;
    end
  end

endmodule // scpd_core

// ==== hw/scpd_mem_if.sv ====
`timescale 1ns/100ps
// Single-port tone memory access
interface scpd_mem_if #(parameter int AW = 8, parameter int DW = 16);
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic          we;
  logic [DW-1:0] rdata;
  modport ctl (output addr, output wdata, output we, input rdata);
  modport mem (input addr, input wdata, input we, output rdata);
endinterface // scpd_mem_if

// ==== hw/scpd_pkg.sv ====
package scpd_pkg;

  // Register byte addresses
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_PDATA  = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] ADR_TPTR   = 8'h0C;
  localparam logic [7:0] ADR_TDATA  = 8'h10;
  localparam logic [7:0] ADR_NAME   = 8'h14;

  // Control fields
  localparam int CTRL_MODE_LSB    = 0;
  localparam int CTRL_FILLCOL_BIT = 2;
  localparam int CTRL_CUSTOM_BIT  = 3;
  localparam int CTRL_V11EN_BIT   = 4;
  localparam int CTRL_FACTORY_BIT = 8;
  localparam int CTRL_PSREQ_BIT   = 9;
  localparam logic [4:0] CTRL_RESET = 5'h10;

  // Process data fields
  localparam int PD_SIREN_LSB = 16;

  // Status fields
  localparam int ST_REV_BIT    = 16;
  localparam int ST_FILLBAD    = 17;
  localparam int ST_SIRENBAD   = 18;
  localparam int ST_BUSY       = 19;
  localparam int ST_CLAMPED    = 20;
  localparam int ST_PSAVAIL    = 21;

  // Value ranges
  localparam logic [7:0] FILL_MAX      = 8'h64;
  localparam logic [7:0] SIREN_MIN     = 8'h01;
  localparam logic [7:0] SIREN_MAX     = 8'h0A;
  localparam logic [6:0] NAME_MAX_V10  = 7'h40;
  localparam logic [6:0] NAME_MAX_V11  = 7'h20;
  localparam int         SEG_MAX       = 15;
  localparam int         TONE_FIELDS   = 9;

  // Timing: LED blink half period
  localparam int CLK_HZ       = 20_000_000;
  localparam int BLINK_HZ     = 2;
  localparam int BLINK_CYC    = CLK_HZ / (2 * BLINK_HZ);

  typedef enum logic [1:0] {
    MODE_INDIV = 2'b00,
    MODE_FILL  = 2'b01,
    MODE_OFF   = 2'b10
  } scpd_mode_e;

  typedef enum logic [2:0] {
    TONE_PERM  = 3'b000,
    TONE_PULSE = 3'b001,
    TONE_RISE  = 3'b010,
    TONE_FALL  = 3'b011,
    TONE_ALT   = 3'b100,
    TONE_SWEEP = 3'b101
  } scpd_tone_e;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_FETCH = 2'b01,
    SEQ_CLEAR = 2'b10
  } scpd_seq_e;

  // Tone record: type, f1, f2, period, vol, repeat, pauses, hold
  typedef logic [TONE_FIELDS-1:0][15:0] scpd_tone_t;

  // Preset frequencies in Hz, periods in ms
  localparam logic [15:0] F_2700 = 16'h0A8C;
  localparam logic [15:0] F_900  = 16'h0384;
  localparam logic [15:0] F_2100 = 16'h0834;
  localparam logic [15:0] F_2650 = 16'h0A5A;
  localparam logic [15:0] F_2800 = 16'h0AF0;
  localparam logic [15:0] F_2300 = 16'h08FC;
  localparam logic [15:0] F_3600 = 16'h0E10;
  localparam logic [15:0] F_1200 = 16'h04B0;
  localparam logic [15:0] F_800  = 16'h0320;
  localparam logic [15:0] P_1HZ  = 16'h03E8;
  localparam logic [15:0] P_05HZ = 16'h07D0;

  function automatic scpd_tone_t scpd_preset(input logic [7:0] n);
    scpd_tone_t t;
    t = '0;
    unique case (n)
      8'h01: begin t[0] = 16'(TONE_PERM);  t[1] = F_2700; end
      8'h02: begin t[0] = 16'(TONE_PERM);  t[1] = F_900;  end
      8'h03: begin t[0] = 16'(TONE_PULSE); t[1] = F_2100; end
      8'h04: begin t[0] = 16'(TONE_PULSE); t[1] = F_900;  end
      8'h05: begin t[0] = 16'(TONE_PULSE); t[1] = F_2650; end
      8'h06: begin
        t[0] = 16'(TONE_PULSE); t[1] = F_900; t[3] = P_1HZ;
      end
      8'h07: begin t[0] = 16'(TONE_PULSE); t[1] = F_2800; end
      8'h08: begin
        t[0] = 16'(TONE_SWEEP); t[1] = F_2300; t[2] = F_3600;
        t[3] = P_05HZ;
      end
      8'h09: begin t[0] = 16'(TONE_PERM);  t[1] = F_2650; end
      8'h0A: begin
        t[0] = 16'(TONE_ALT); t[1] = F_1200; t[2] = F_800;
        t[3] = P_1HZ;
      end
      default: t = '0;
    endcase
    return t;
  endfunction

endpackage

// ==== hw/scpd_tone_mem.sv ====
`timescale 1ns/100ps
module scpd_tone_mem #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  input  wire logic clk_i,
  scpd_mem_if.mem   port
);
  logic [DW-1:0] store [0:(1<<AW)-1];

  // Registered read, write-first is not needed here
  always_ff @(posedge clk_i) begin
    if (port.we) begin
      store[port.addr] <= port.wdata;
    end
    port.rdata <= store[port.addr];
  end
endmodule // scpd_tone_mem

// ==== test/scpd_core_asserts.sv ====
`timescale 1ns/100ps
module scpd_core_asserts
  import scpd_pkg::*;
#(
  parameter int SEG_COUNT = 15,
  parameter int BLINK_CNT = 4
) (
  input wire logic                      clk_i,
  input wire logic                      resetn_i,
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_we_i,
  input wire logic [7:0]                wb_adr_i,
  input wire logic [3:0]                wb_sel_i,
  input wire logic [31:0]               wb_dat_i,
  input wire logic [31:0]               wb_dat_o,
  input wire logic                      wb_ack_o,
  input wire logic                      master_v11_i,
  input wire logic [SEG_MAX-1:0]        seg_on_o,
  input wire logic [4*SEG_MAX-1:0]      seg_set_o,
  input wire logic                      tone_on_o,
  input wire logic [16*TONE_FIELDS-1:0] tone_o,
  input wire logic                      led_o,
  input wire logic                      ps_backup_o
);
  import scpd_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // Shadow of the mode field, updated one edge after the accepting edge, while ack is high
  logic [1:0] mode_q;
  wire  logic wr_ctrl = wb_ack_o & wb_we_i & wb_sel_i[0]
                        & (wb_adr_i == ADR_CTRL);
  always_ff @(posedge clk_i) begin
    if (!resetn_i) mode_q <= CTRL_RESET[1:0];
    else if (wr_ctrl) mode_q <= wb_dat_i[1:0];
  end

  // Bus answer shape
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    && wb_adr_i != ADR_TDATA |=> wb_ack_o)
    else $error("register access not answered next cycle");
  a_rdata_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  // Outputs tied to the decoded state
  a_unused_segs: assert property (seg_on_o >> SEG_COUNT == '0)
    else $error("segment beyond variant lit");
  a_fill_bar: assert property (mode_q == 2'h1 && $past(mode_q, 2) == 2'h1
    |-> (seg_on_o & (seg_on_o + 15'h1)) == '0)
    else $error("fill bar not contiguous from segment 1");
  a_silent_zero: assert property (!tone_on_o |-> tone_o == '0)
    else $error("tone fields set while silent");
  a_tone_kind: assert property (tone_on_o |-> tone_o[15:0] <= 16'h5)
    else $error("tone type out of range");
  a_led_steady: assert property ((master_v11_i == 1'b0) [*3] |-> led_o)
    else $error("led not steady under older revision");
  a_ps_newer: assert property (ps_backup_o |-> master_v11_i)
    else $error("backup under older revision");
endmodule // scpd_core_asserts

bind scpd_core scpd_core_asserts #(
  .SEG_COUNT(SEG_COUNT),
  .BLINK_CNT(BLINK_CNT)
) u_chk (.*);

// ==== test/scpd_core_tb.sv ====
`timescale 1ns/100ps
module scpd_core_tb;
  import scpd_pkg::*;
  logic         clk = 0, resetn = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0]   adr = '0;
  logic [31:0]  wdat = '0;
  logic         ps_seen = 0;
  wire  logic [31:0]  rdat;
  wire  logic         ack, v11, tone_on, led, ps;
  wire  logic [14:0]  seg;
  wire  logic [59:0]  sset;
  wire  logic [143:0] tone;
  int           fails = 0, cmp_count = 0;

  scpd_master_model far (.v11_o(v11));
  scpd_core #(.SEG_COUNT(15), .BLINK_CNT(4)) dut (
    .clk_i(clk), .resetn_i(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .master_v11_i(v11),
    .seg_on_o(seg), .seg_set_o(sset), .tone_on_o(tone_on), .tone_o(tone),
    .led_o(led), .ps_backup_o(ps));

  // Clock, and a latch for the one-cycle backup pulse
  always #25 clk = ~clk;
  always @(posedge clk) if (ps === 1'b1) ps_seen <= 1'b1;

  task automatic chk(input string n, input logic [143:0] s, e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask
  // One classic cycle; ack and data taken at the same edge
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, '0, q);
  endtask
  // Polls busy; the watchdog cuts a hang
  task automatic idle();
    logic [31:0] q;
    do rd(ADR_STATUS, q); while (q[ST_BUSY] !== 1'b0);
    repeat (2) @(posedge clk);
  endtask

  task automatic t_reset();
    logic [31:0] q;
    rd(ADR_CTRL, q); chk("ctrl", q[4:0], CTRL_RESET);
    chk("off", {seg, tone_on}, '0);
    rd(8'h3C, q); chk("unmapped", q, '0);
    $display("reset test done");
  endtask
  task automatic t_fill();
    int p [4] = '{0, 50, 100, 101};
    wr(ADR_CTRL, 32'h11);
    foreach (p[i]) begin
      wr(ADR_PDATA, 32'(p[i]));
      repeat (2) @(posedge clk);
      chk("bar", seg, p[i] > 100 ? 0 : (1 << (p[i] * 15 / 100)) - 1);
    end
    wr(ADR_PDATA, 32'd100); repeat (2) @(posedge clk);
    chk("own set", sset[59:56], 4'hF);
    wr(ADR_CTRL, 32'h15); repeat (2) @(posedge clk);
    chk("seg1 set", sset[59:56], 4'h1);
    $display("fill test done");
  endtask
  task automatic t_indiv();
    logic [15:0] p [3] = '{16'hFFFF, 16'h8001, 16'h4100};
    wr(ADR_CTRL, 32'h10);
    foreach (p[i]) begin
      wr(ADR_PDATA, {16'h0, p[i]});
      repeat (2) @(posedge clk);
      chk("bits", seg, p[i][14:0]);
    end
    chk("set9", sset[35:32], 4'h9);
    wr(ADR_CTRL, 32'h12);
    repeat (2) @(posedge clk);
    chk("off mode", seg, '0);
    $display("individual test done");
  endtask
  task automatic t_siren();
    logic [15:0] ty [10] = '{0, 0, 1, 1, 1, 1, 1, 5, 0, 4};
    logic [47:0] fq [10] = '{{32'h0, F_2700}, {32'h0, F_900},
      {32'h0, F_2100}, {32'h0, F_900}, {32'h0, F_2650},
      {P_1HZ, 16'h0, F_900}, {32'h0, F_2800}, {P_05HZ, F_3600, F_2300},
      {32'h0, F_2650}, {P_1HZ, F_800, F_1200}};
    for (int n = 0; n < 12; n++) begin
      wr(ADR_PDATA, {8'h0, 8'(n), 16'h0});
      idle();
      if (n == 0 || n > 10) chk("silent", {tone_on, tone}, '0);
      else chk("preset", {tone_on, tone[63:0]}, {1'b1, fq[n-1], ty[n-1]});
    end
    $display("siren test done");
  endtask
  task automatic t_custom();
    logic [31:0] q;
    logic [143:0] e;
    for (int f = 0; f < 9; f++) begin
      e[16*f +: 16] = f == 0 ? 16'h5 : 16'h1000 + 16'(f);
      wr(ADR_TPTR, {24'h0, 4'h2, 4'(f)}); idle();
      wr(ADR_TDATA, {16'h0, e[16*f +: 16]});
    end
    wr(ADR_TPTR, 32'h23); idle(); rd(ADR_TDATA, q);
    chk("slot read", q[15:0], 16'h1003);
    wr(ADR_CTRL, 32'h18); wr(ADR_PDATA, 32'h30000); idle();
    chk("custom", tone, e);
    wr(ADR_TPTR, 32'h20);
    idle();
    wr(ADR_TDATA, 32'h7);
    idle();
    chk("bad type", {tone_on, tone}, '0);
    $display("custom tone test done");
  endtask
  task automatic t_factory();
    logic [31:0] q;
    wr(ADR_CTRL, 32'h100); idle();
    rd(ADR_CTRL, q); chk("ctrl dflt", q[4:0], CTRL_RESET);
    wr(ADR_TPTR, 32'h23); idle(); rd(ADR_TDATA, q);
    chk("wiped", q[15:0], 16'h0);
    $display("factory test done");
  endtask
  task automatic t_rev();
    logic [31:0] q;
    int lo;
    for (int v = 0; v < 2; v++) begin
      far.set_rev(v[0]);
      wr(ADR_NAME, 32'h64); rd(ADR_NAME, q);
      chk("name", q[6:0], v ? NAME_MAX_V11 : NAME_MAX_V10);
      rd(ADR_STATUS, q); chk("rev", q[ST_REV_BIT], v[0]);
      ps_seen <= 1'b0; wr(ADR_CTRL, 32'h210); repeat (3) @(posedge clk);
      chk("backup", ps_seen, v[0]);
      lo = 0;
      repeat (12) begin @(posedge clk); lo += (led !== 1'b1); end
      chk("blink", lo != 0, v[0]);
    end
    $display("revision test done");
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Roughly sixty times the expected run
  initial begin
    #2_000_000;
    fails++;
    test_done();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_reset(); t_fill(); t_indiv(); t_siren();
    t_custom(); t_factory(); t_rev();
    test_done();
  end
endmodule // scpd_core_tb

// ==== test/scpd_master_model.sv ====
`timescale 1ns/100ps
// Far-side master: reports the revision it speaks
module scpd_master_model (
  output logic v11_o
);
  // Older master at power-up
  initial v11_o = 1'b0;
  // Called right after a clock edge
  task automatic set_rev(input logic v);
    v11_o <= v;
  endtask
endmodule // scpd_master_model
